// ===== diag_map_pkg.sv
// constants, types and states for the module management two-wire target
// assumes a single core clock; serial clock and data arrive as raw pins
// =====================================================================
// Functional notes
// - data sampled on serial clock rise; writes skip protected map segments
// - target changes its outgoing data bit after a serial clock fall, or releases it at start or stop
// - memory is 8-bit bytes from address zero, random and sequential access
// - 128-byte lower page always visible plus a shared upper window
// - host-written page select picks which page fills the upper window
// - lower page and upper pages 00 and 03 always exist; 01, 02 optional
// - page 01 holds application table, page 02 is user read/write space
// - target answers only at bus address A0h
// - flags and monitors sit in the lower page for one-pass reading
// - alarm and warning flags set when a monitor leaves its threshold range
// - temperature, bias, tx power, rx power and supply readings are mapped
package diag_map_pkg;
  // =================================================================
  // bus address and map layout
  localparam logic [6:0] DEV_ADDR      = 7'h50;  // A0h with r/w bit clear
  localparam logic [7:0] FLAG_BASE     = 8'h03;  // one flag byte per monitor
  localparam logic [7:0] MON_BASE      = 8'h16;  // two bytes per monitor, msb first
  localparam logic [7:0] LOWER_WR_BASE = 8'h56;  // lower bytes below are read only
  localparam logic [7:0] PAGE_SEL_ADDR = 8'h7F;
  localparam logic [6:0] THR_END       = 7'h28;  // threshold bytes in page 03
  localparam logic [1:0] PG_ID         = 2'h0;
  localparam logic [1:0] PG_APP        = 2'h1;
  localparam logic [1:0] PG_USER       = 2'h2;
  localparam logic [1:0] PG_THR        = 2'h3;
  localparam logic [7:0] ABSENT_BYTE   = 8'hFF;
  localparam int         NUM_MON       = 5;
  localparam int         MEM_BYTES     = 640;    // lower page plus four pages
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  // =================================================================
  // factory threshold defaults, order: hi alarm, lo alarm, hi warn, lo warn
  localparam logic [15:0] THR_DEF_HA = 16'hC000;
  localparam logic [15:0] THR_DEF_LA = 16'h1000;
  localparam logic [15:0] THR_DEF_HW = 16'hB000;
  localparam logic [15:0] THR_DEF_LW = 16'h2000;
  // =================================================================
  // live monitor readings, temp is monitor 0 in the map
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] bias;
    logic [15:0] tx_pwr;
    logic [15:0] rx_pwr;
    logic [15:0] supply;
  } monitor_set_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WADDR, ST_WADDR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } twi_state_t;
endpackage : diag_map_pkg

// ===== diag_twowire_target.sv
// two-wire management target with paged memory map and diagnostics flags
// assumes monitor readings come from logic on the core clock
`timescale 1ns/1ps
module diag_twowire_target #(
  parameter bit HAS_APP_PAGE  = 1'b1,
  parameter bit HAS_USER_PAGE = 1'b1
) (
  // clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       resetn_in,
  // two-wire pins, data is open-drain
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe_out,
  // diagnostics
  input  wire diag_map_pkg::monitor_set_t monitors_in,
  output logic                            attention_request_n_out
);
  // =================================================================
  // pin synchronisers and edge detection
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic       scl_d_reg, sda_d_reg;
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  assign scl_s     = scl_sync_reg[1];
  assign sda_s     = sda_sync_reg[1];
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  // host framing, sda moves while scl high
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  // =================================================================
  // protocol state
  diag_map_pkg::twi_state_t state_reg;
  logic [7:0] shift_reg, tx_reg, ptr_reg, page_sel_reg;
  logic [3:0] bit_cnt_reg;
  logic       rw_reg, mack_reg, sda_oe_reg, wr_pulse, rd_load;
  logic [7:0] rd_byte;
  logic       addr_hit, ack_slot;
  assign addr_hit = shift_reg[7:1] == diag_map_pkg::DEV_ADDR;
  // ninth clock of every byte, the counter restarts after its fall
  assign ack_slot = state_reg == diag_map_pkg::ST_ADDR_ACK ||
                    state_reg == diag_map_pkg::ST_WADDR_ACK ||
                    state_reg == diag_map_pkg::ST_WDATA_ACK ||
                    state_reg == diag_map_pkg::ST_RDATA_ACK;
  assign wr_pulse = scl_fall && state_reg == diag_map_pkg::ST_WDATA &&
                    bit_cnt_reg == diag_map_pkg::BYTE_BITS;
  assign rd_load  = scl_fall && ((state_reg == diag_map_pkg::ST_ADDR_ACK && rw_reg) ||
                    (state_reg == diag_map_pkg::ST_RDATA_ACK && !mack_reg));
  // sampling on serial clock rise
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shift_reg <= 8'h00;
      mack_reg  <= 1'b1;
    end else if (scl_rise) begin
      shift_reg <= {shift_reg[6:0], sda_s};
      if (state_reg == diag_map_pkg::ST_RDATA_ACK) mack_reg <= sda_s;
    end
  end
  // bit counter, cleared at start, at each byte boundary and after the ack clock
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) bit_cnt_reg <= 4'h0;
    else if (start_det) bit_cnt_reg <= 4'h0;
    else if (scl_fall && (bit_cnt_reg == diag_map_pkg::BYTE_BITS || ack_slot))
      bit_cnt_reg <= 4'h0;
    else if (scl_rise) bit_cnt_reg <= bit_cnt_reg + 4'h1;
  end
  // state and data line drive, updated after scl falls and on start or stop
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg  <= diag_map_pkg::ST_IDLE;
      sda_oe_reg <= 1'b0;
      rw_reg     <= 1'b0;
      tx_reg     <= 8'h00;
    end else if (start_det) begin
      state_reg  <= diag_map_pkg::ST_ADDR;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg  <= diag_map_pkg::ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (scl_fall) begin
      case (state_reg)
        diag_map_pkg::ST_ADDR: if (bit_cnt_reg == diag_map_pkg::BYTE_BITS) begin
          if (addr_hit) begin
            sda_oe_reg <= 1'b1;
            rw_reg     <= shift_reg[0];
            state_reg  <= diag_map_pkg::ST_ADDR_ACK;
          end else state_reg <= diag_map_pkg::ST_IDLE;
        end
        diag_map_pkg::ST_WADDR, diag_map_pkg::ST_WDATA:
          if (bit_cnt_reg == diag_map_pkg::BYTE_BITS) begin
            sda_oe_reg <= 1'b1;
            state_reg  <= (state_reg == diag_map_pkg::ST_WADDR) ?
                          diag_map_pkg::ST_WADDR_ACK : diag_map_pkg::ST_WDATA_ACK;
          end
        diag_map_pkg::ST_WADDR_ACK, diag_map_pkg::ST_WDATA_ACK: begin
          sda_oe_reg <= 1'b0;
          state_reg  <= diag_map_pkg::ST_WDATA;
        end
        diag_map_pkg::ST_ADDR_ACK, diag_map_pkg::ST_RDATA_ACK: begin
          if (rd_load) begin
            sda_oe_reg <= ~rd_byte[7];
            tx_reg     <= {rd_byte[6:0], 1'b1};
            state_reg  <= diag_map_pkg::ST_RDATA;
          end else if (state_reg == diag_map_pkg::ST_ADDR_ACK) begin
            sda_oe_reg <= 1'b0;
            state_reg  <= diag_map_pkg::ST_WADDR;
          end else begin
            sda_oe_reg <= 1'b0;  // host nack ends the read
            state_reg  <= diag_map_pkg::ST_IDLE;
          end
        end
        diag_map_pkg::ST_RDATA: begin
          if (bit_cnt_reg == diag_map_pkg::BYTE_BITS) begin
            sda_oe_reg <= 1'b0;
            state_reg  <= diag_map_pkg::ST_RDATA_ACK;
          end else begin
            sda_oe_reg <= ~tx_reg[7];
            tx_reg     <= {tx_reg[6:0], 1'b1};
          end
        end
        default: state_reg <= diag_map_pkg::ST_IDLE;
      endcase
    end
  end
  // byte pointer: set by the address byte, advanced per byte moved
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) ptr_reg <= 8'h00;
    else if (scl_fall && state_reg == diag_map_pkg::ST_WADDR &&
             bit_cnt_reg == diag_map_pkg::BYTE_BITS) ptr_reg <= shift_reg;
    else if (wr_pulse || rd_load) ptr_reg <= ptr_reg + 8'h01;
  end
  // =================================================================
  // memory map decode
  logic [2:0]  bank;
  logic [9:0]  mem_idx;
  logic        page_absent, upper_ok;
  logic [6:0]  off;
  logic [7:0]  mon_off;
  logic [15:0] thr_reg [diag_map_pkg::NUM_MON][4];
  logic [3:0]  flag_reg [diag_map_pkg::NUM_MON];
  logic [15:0] mon_val [diag_map_pkg::NUM_MON];
  logic [7:0]  mem [diag_map_pkg::MEM_BYTES];
  assign off     = ptr_reg[6:0];
  assign mon_off = ptr_reg - diag_map_pkg::MON_BASE;
  // upper window lands on page select plus one
  assign bank    = ptr_reg[7] ? {1'b0, page_sel_reg[1:0]} + 3'h1 : 3'h0;
  assign mem_idx = {bank, off};
  assign page_absent = (page_sel_reg > {6'h00, diag_map_pkg::PG_THR}) ||
         (page_sel_reg[1:0] == diag_map_pkg::PG_APP && !HAS_APP_PAGE) ||
         (page_sel_reg[1:0] == diag_map_pkg::PG_USER && !HAS_USER_PAGE);
  // id and app pages read only, user and threshold pages writable
  assign upper_ok = !page_absent && (page_sel_reg[1:0] == diag_map_pkg::PG_THR ||
                    page_sel_reg[1:0] == diag_map_pkg::PG_USER);
  // read byte mux
  always_comb begin
    rd_byte = mem[mem_idx];
    if (!ptr_reg[7]) begin
      for (int j = 0; j < diag_map_pkg::NUM_MON; j++) begin
        if (ptr_reg == diag_map_pkg::FLAG_BASE + 8'(j))
          rd_byte = {4'h0, flag_reg[j]};
        if (mon_off[7:1] == 7'(j))
          rd_byte = mon_off[0] ? mon_val[j][7:0] : mon_val[j][15:8];
      end
      if (ptr_reg == diag_map_pkg::PAGE_SEL_ADDR) rd_byte = page_sel_reg;
    end else if (page_absent) rd_byte = diag_map_pkg::ABSENT_BYTE;
    else if (page_sel_reg[1:0] == diag_map_pkg::PG_THR && off < diag_map_pkg::THR_END)
      rd_byte = off[0] ? thr_reg[off[5:3]][off[2:1]][7:0] : thr_reg[off[5:3]][off[2:1]][15:8];
  end
  // page select register
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) page_sel_reg <= 8'h00;
    else if (wr_pulse && ptr_reg == diag_map_pkg::PAGE_SEL_ADDR) page_sel_reg <= shift_reg;
  end
  // byte storage, protected segments ignore writes
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < diag_map_pkg::MEM_BYTES; i++) mem[i] <= 8'h00;
    end else if (wr_pulse && (ptr_reg[7] ? upper_ok : ptr_reg >= diag_map_pkg::LOWER_WR_BASE))
      mem[mem_idx] <= shift_reg;
  end
  // =================================================================
  // per monitor thresholds and sticky flags
  assign {mon_val[0], mon_val[1], mon_val[2], mon_val[3], mon_val[4]} = monitors_in;
  for (genvar j = 0; j < diag_map_pkg::NUM_MON; j++) begin : g_mon
    logic       thr_wr, flag_clr;
    logic [3:0] flag_set;
    assign thr_wr   = wr_pulse && ptr_reg[7] && !page_absent && off[5:3] == 3'(j) &&
                      page_sel_reg[1:0] == diag_map_pkg::PG_THR && off < diag_map_pkg::THR_END;
    assign flag_clr = rd_load && ptr_reg == diag_map_pkg::FLAG_BASE + 8'(j);
    assign flag_set = {mon_val[j] < thr_reg[j][3], mon_val[j] > thr_reg[j][2],
                       mon_val[j] < thr_reg[j][1], mon_val[j] > thr_reg[j][0]};
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        thr_reg[j][0] <= diag_map_pkg::THR_DEF_HA;
        thr_reg[j][1] <= diag_map_pkg::THR_DEF_LA;
        thr_reg[j][2] <= diag_map_pkg::THR_DEF_HW;
        thr_reg[j][3] <= diag_map_pkg::THR_DEF_LW;
      end else if (thr_wr) begin
        if (off[0]) thr_reg[j][off[2:1]][7:0] <= shift_reg;
        else thr_reg[j][off[2:1]][15:8] <= shift_reg;
      end
    end
    // set wins over clear-on-read
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) flag_reg[j] <= 4'h0;
      else flag_reg[j] <= (flag_reg[j] & ~{4{flag_clr}}) | flag_set;
    end
    property p_hi_alarm;
      @(posedge core_clk_in) disable iff (!resetn_in)
        (mon_val[j] > thr_reg[j][0]) |=> flag_reg[j][0];
    endproperty
    a_hi_alarm: assert property (p_hi_alarm) else $error("hi alarm flag not set");
  end
  // attention request, low while any flag stands
  logic attn_n_reg;
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) attn_n_reg <= 1'b1;
    else attn_n_reg <= ~|{flag_reg[0], flag_reg[1], flag_reg[2], flag_reg[3], flag_reg[4]};
  end
  assign attention_request_n_out = attn_n_reg;
  assign sda_oe_out = sda_oe_reg;
  assign sda_out    = 1'b0;  // open-drain, only ever pulls low
  // =================================================================
  // assertions
  property p_oe_on_fall;
    @(posedge core_clk_in) disable iff (!resetn_in)
      $changed(sda_oe_reg) |-> $past(scl_fall || start_det || stop_det);
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall) else $error("sda drive moved off a fall");
  property p_addr_ack;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (scl_fall && !start_det && !stop_det && state_reg == diag_map_pkg::ST_ADDR &&
       bit_cnt_reg == diag_map_pkg::BYTE_BITS && addr_hit) |=> sda_oe_reg;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
  property p_addr_miss;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (scl_fall && !start_det && !stop_det && state_reg == diag_map_pkg::ST_ADDR &&
       bit_cnt_reg == diag_map_pkg::BYTE_BITS && !addr_hit)
      |=> !sda_oe_reg && state_reg == diag_map_pkg::ST_IDLE;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered");
  property p_ptr_step;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (wr_pulse && !start_det && !stop_det) |=> ptr_reg == $past(ptr_reg) + 8'h01 ##0 sda_oe_reg;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("write did not advance or ack");
  property p_sample;
    @(posedge core_clk_in) disable iff (!resetn_in)
      scl_rise |=> shift_reg[0] == $past(sda_s);
  endproperty
  a_sample: assert property (p_sample) else $error("bit not sampled on rise");
  property p_page_sel;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (wr_pulse && ptr_reg == diag_map_pkg::PAGE_SEL_ADDR) |=> page_sel_reg == $past(shift_reg);
  endproperty
  a_page_sel: assert property (p_page_sel) else $error("page select not stored");
  property p_absent;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (rd_load && !start_det && !stop_det && ptr_reg[7] &&
       page_sel_reg > {6'h00, diag_map_pkg::PG_THR}) |=> !sda_oe_reg;
  endproperty
  a_absent: assert property (p_absent) else $error("absent page bit 7 not high");
  property p_attn;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (flag_reg[0] != 4'h0) |=> !attn_n_reg;
  endproperty
  a_attn: assert property (p_attn) else $error("attention not raised");
  c_addr_hit: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
    state_reg == diag_map_pkg::ST_ADDR_ACK);
  c_write: cover property (@(posedge core_clk_in) disable iff (!resetn_in) wr_pulse);
  c_seq_read: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
    rd_load && state_reg == diag_map_pkg::ST_RDATA_ACK);
endmodule : diag_twowire_target

// ===== twowire_host_model.sv
// behavioural host controller driving the two-wire bus
// assumes the bench pulls sda up and returns the wire level
`timescale 1ns/1ps
module twowire_host_model (
  // pacing clock
  input  wire logic clk_in,
  // two-wire pins
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // =====================================================================
  // idle bus: clock parked high, data released
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end
  // wait n core cycles on the falling core edge
  task automatic gap(input int n);
    repeat (n) @(negedge clk_in);
  endtask : gap
  // one clock pulse, 4 low and 4 high cycles, sample mid high
  task automatic pulse(output logic bit_out);
    gap(3);
    scl_out = 1'b1;
    gap(2);
    bit_out = sda_in;
    gap(2);
    scl_out = 1'b0;
    gap(1);
  endtask : pulse
  task automatic put_bit(input logic b);
    logic unused;
    sda_low_out = ~b;
    pulse(unused);
  endtask : put_bit
  // start, or repeated start from a low clock
  task automatic start_cond();
    if (scl_out === 1'b0) begin
      sda_low_out = 1'b0;
      gap(3);
      scl_out = 1'b1;
      gap(4);
    end
    sda_low_out = 1'b1;
    gap(4);
    scl_out = 1'b0;
    gap(1);
  endtask : start_cond
  task automatic stop_cond();
    sda_low_out = 1'b1;
    gap(3);
    scl_out = 1'b1;
    gap(4);
    sda_low_out = 1'b0;
    gap(4);
  endtask : stop_cond
  // byte out msb first, then sample the target ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    sda_low_out = 1'b0;
    pulse(s);
    ack = (s === 1'b0);
  endtask : send_byte
  // byte in msb first, ack when more bytes wanted
  task automatic get_byte(input logic more, output logic [7:0] b);
    logic s;
    sda_low_out = 1'b0;
    for (int i = 0; i < 8; i++) begin
      pulse(s);
      b = {b[6:0], s};
    end
    put_bit(~more);
  endtask : get_byte
endmodule : twowire_host_model

// ===== tb_module_diag_twowire_memory_map.sv
// self-checking bench for the two-wire management target
// assumes diag_map_pkg and twowire_host_model are compiled first
`timescale 1ns/1ps
module tb_module_diag_twowire_memory_map;
  localparam int          LIMIT    = 40000;
  localparam logic [79:0] MON_NORM = 80'h4A12_5B34_6C56_7D78_3E9A;
  logic                       core_clk;
  logic                       reset_n;
  logic                       scl;
  logic                       sda_low;
  logic                       sda_wire;
  logic                       sda_out;
  logic                       sda_oe;
  logic                       attention_request_n;
  logic                       oe_prev;
  diag_map_pkg::monitor_set_t mon;
  int                         errors = 0;
  int                         checks = 0;
  int                         cycles = 0;
  // =====================================================================
  // wire level: pulled up, low if either party pulls
  assign sda_wire = ((sda_oe === 1'b1 && sda_out === 1'b0) || sda_low) ? 1'b0 : 1'b1;
  twowire_host_model i_host (.clk_in(core_clk), .sda_in(sda_wire), .scl_out(scl),
                             .sda_low_out(sda_low));
  diag_twowire_target i_dut (.core_clk_in(core_clk), .resetn_in(reset_n), .scl_in(scl),
                             .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_out(sda_oe),
                             .monitors_in(mon),
                             .attention_request_n_out(attention_request_n));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // =====================================================================
  // compare and report
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte
  // hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      tally_and_finish();
    end
  end
  // target data may only move while the serial clock is low
  always @(posedge core_clk) begin
    #1;
    if (reset_n === 1'b1 && sda_oe !== oe_prev) chk_bit(scl, 1'b0);
    oe_prev = sda_oe;
  end
  // =====================================================================
  // bus transactions at device address A0h
  task automatic addr_ptr(input logic [7:0] ptr);
    logic ack;
    i_host.start_cond();
    i_host.send_byte(8'hA0, ack);
    chk_bit(ack, 1'b1);
    i_host.send_byte(ptr, ack);
    chk_bit(ack, 1'b1);
  endtask : addr_ptr
  task automatic wr(input logic [7:0] ptr, input logic [7:0] data[$]);
    logic ack;
    addr_ptr(ptr);
    foreach (data[i]) begin
      i_host.send_byte(data[i], ack);
      chk_bit(ack, 1'b1);
    end
    i_host.stop_cond();
  endtask : wr
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp[$]);
    logic       ack;
    logic [7:0] b;
    addr_ptr(ptr);
    i_host.start_cond();
    i_host.send_byte(8'hA1, ack);
    chk_bit(ack, 1'b1);
    foreach (exp[i]) begin
      i_host.get_byte(i < exp.size() - 1, b);
      chk_byte(b, exp[i]);
    end
    i_host.stop_cond();
  endtask : rd
  // current address read, no pointer byte sent
  task automatic rd_cur(input logic [7:0] exp);
    logic       ack;
    logic [7:0] b;
    i_host.start_cond();
    i_host.send_byte(8'hA1, ack);
    chk_bit(ack, 1'b1);
    i_host.get_byte(1'b0, b);
    chk_byte(b, exp);
    i_host.stop_cond();
  endtask : rd_cur
  // =====================================================================
  // scenarios
  task automatic t_ram_and_protect();
    logic [7:0] q[$];
    wr(8'h56, '{8'h11, 8'h22, 8'h33});
    rd(8'h56, '{8'h11, 8'h22, 8'h33});
    wr(8'h16, '{8'hAA, 8'h55});
    for (int k = 0; k < 10; k++) q.push_back(MON_NORM[79 - 8 * k -: 8]);
    rd(8'h16, q);
  endtask : t_ram_and_protect
  task automatic t_wrong_addr();
    logic ack;
    i_host.start_cond();
    i_host.send_byte(8'hA2, ack);
    chk_bit(ack, 1'b0);
    i_host.stop_cond();
  endtask : t_wrong_addr
  task automatic t_pages();
    logic [7:0] pg[5]  = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05};
    logic [7:0] exp[5] = '{8'h00, 8'h00, 8'h5A, 8'h5A, 8'hFF};
    wr(8'h7F, '{8'h03});
    rd(8'h80, '{8'hC0, 8'h00, 8'h10, 8'h00, 8'hB0, 8'h00, 8'h20, 8'h00});
    for (int i = 0; i < 5; i++) begin
      wr(8'h7F, '{pg[i]});
      wr(8'hC0, '{8'h5A});
      rd(8'hC0, '{exp[i]});
      rd(8'h56, '{8'h11});
    end
    rd_cur(8'h22);
    wr(8'h7F, '{8'h00});
  endtask : t_pages
  task automatic t_alarm();
    @(negedge core_clk);
    mon.temp = 16'hD000;
    mon.bias = 16'h0800;
    repeat (6) @(negedge core_clk);
    chk_bit(attention_request_n, 1'b0);
    mon = MON_NORM;
    rd(8'h03, '{8'h05, 8'h0A, 8'h00});
    repeat (6) @(negedge core_clk);
    chk_bit(attention_request_n, 1'b1);
    rd(8'h03, '{8'h00, 8'h00});
  endtask : t_alarm
  // =====================================================================
  // main sequence
  initial begin
    reset_n = 1'b0;
    mon     = MON_NORM;
    oe_prev = 1'b0;
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    chk_bit(sda_oe, 1'b0);
    chk_bit(attention_request_n, 1'b1);
    t_ram_and_protect();
    t_wrong_addr();
    t_pages();
    t_alarm();
    tally_and_finish();
  end
endmodule : tb_module_diag_twowire_memory_map
